/* File: rtl/radio_ctrl.sv */
// Radio control register bank with strength-hysteresis data validation
//
// Functional notes
// - Three-bit transmit power level, reset lowest
// - Transmit pair select picks frequency registers
// - Two-bit receive register select, reset two
// - Crystal select bit, reset lower crystal
// - Width bit only in legacy mode
// - Polarity zero inverts data, one passes
// - Slicer reference select, reset internal level
// - Offset bit routes ADC: supply/discriminator
// - Extended mode bit, timing register 32
// - Supply measure freezes held strength value
// - No supply measure during power down
// - Discriminator measure concurrent with supply
// - Validate data at threshold plus hysteresis
// - Inhibit data below threshold minus hysteresis
// - Between levels keep previous decision
// - Select bit stores strength or supply
// - Six-bit threshold, three-bit hysteresis, reset zero
`timescale 1ns/1ps
module radio_ctrl (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // ADC results
   input wire logic adc_valid_i,
   input wire logic [5:0] adc_value_i,
   input wire logic offset_valid_i,
   input wire logic [5:0] offset_value_i,
   // Demodulator and extended timing register
   input wire logic demod_bit_i,
   input wire logic [1:0] discriminator_range_i,
   // Data pin
   input wire logic rx_tx_data_pin_i,
   output logic rx_tx_data_pin_o,
   output logic rx_tx_data_pin_oe_o,
   // Radio controls
   output logic [2:0] tx_power_level_o,
   output logic [1:0] freq_reg_index_o,
   output logic crystal_select_o,
   output logic [1:0] discriminator_range_o,
   output logic slicer_reference_select_o,
   output logic adc_offset_measure_o,
   output logic supply_measure_active_o,
   output logic extended_mode_enable_o,
   output logic [5:0] timing_length_o,
   output logic data_valid_o,
   output logic [31:0] rate_and_lock_control_o
);

   // ==========================================
   // Registers and bus decode
   logic [31:0] main_control_r;
   logic [31:0] rate_and_lock_control_r;
   logic [5:0] measured_strength_r;
   logic [5:0] supply_value_r;
   logic [5:0] offset_value_r;
   radio_ctrl_pkg::valid_state_e val_state_r;
   radio_ctrl_pkg::valid_state_e val_state_nxt;
   logic ack_r;
   logic [31:0] dat_r;
   logic req;
   logic wr_take;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   assign req = cyc_i & stb_i;
   // Write lands on the edge where the master samples ack high
   assign wr_take = req & we_i & ack_r;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[radio_ctrl_pkg::ST_VALID] = val_state_r;
      status_word[radio_ctrl_pkg::ST_STR_HI:radio_ctrl_pkg::ST_STR_LO] = measured_strength_r;
      status_word[radio_ctrl_pkg::ST_SUP_HI:radio_ctrl_pkg::ST_SUP_LO] = supply_value_r;
      status_word[radio_ctrl_pkg::ST_OFS_HI:radio_ctrl_pkg::ST_OFS_LO] = offset_value_r;
   end

   always_comb begin
      unique case (adr_i)
         radio_ctrl_pkg::OFS_MAIN: rd_mux = main_control_r;
         radio_ctrl_pkg::OFS_RATE: rd_mux = rate_and_lock_control_r;
         radio_ctrl_pkg::OFS_STATUS: rd_mux = status_word;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // One-cycle ack per request; unmapped addresses are acked too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= req & ~ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else if (ce_i && req && !ack_r) begin
         dat_r <= rd_mux;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   // reset loads and full-word writes only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_control_r <= radio_ctrl_pkg::MAIN_RESET;
         rate_and_lock_control_r <= radio_ctrl_pkg::RATE_RESET;
      end else if (ce_i && wr_take && sel_i == radio_ctrl_pkg::SEL_ALL) begin
         if (adr_i == radio_ctrl_pkg::OFS_MAIN) begin
            main_control_r <= dat_i & ~radio_ctrl_pkg::MAIN_RESV_MASK;
         end
         if (adr_i == radio_ctrl_pkg::OFS_RATE) begin
            rate_and_lock_control_r <= dat_i;
         end
      end
   end

   // ==========================================
   // Field decode
   logic power_on;
   logic tx_mode;
   logic polarity;
   logic ext_mode;
   logic supply_active;
   logic [5:0] threshold;
   logic [2:0] hysteresis;

   assign power_on = main_control_r[radio_ctrl_pkg::BIT_POWER_ON];
   assign tx_mode = main_control_r[radio_ctrl_pkg::BIT_TX_MODE];
   assign polarity = main_control_r[radio_ctrl_pkg::BIT_POLARITY];
   assign ext_mode = main_control_r[radio_ctrl_pkg::BIT_EXT_MODE];
   assign threshold = main_control_r[radio_ctrl_pkg::THR_HI:radio_ctrl_pkg::THR_LO];
   assign hysteresis = main_control_r[radio_ctrl_pkg::HYS_HI:radio_ctrl_pkg::HYS_LO];
   assign supply_active = main_control_r[radio_ctrl_pkg::BIT_SUPPLY_SEL] & power_on;

   assign tx_power_level_o = main_control_r[radio_ctrl_pkg::TX_POWER_LEVEL_HI:radio_ctrl_pkg::TX_POWER_LEVEL_LO];
   assign crystal_select_o = main_control_r[radio_ctrl_pkg::BIT_CRYSTAL];
   assign slicer_reference_select_o = main_control_r[radio_ctrl_pkg::BIT_SLICER_REF];
   assign adc_offset_measure_o = main_control_r[radio_ctrl_pkg::BIT_OFFSET_MEAS];
   assign supply_measure_active_o = supply_active;
   assign extended_mode_enable_o = ext_mode;
   assign rate_and_lock_control_o = rate_and_lock_control_r;
   assign timing_length_o = ext_mode ? 6'(radio_ctrl_pkg::EXT_TIMING_LEN) : 6'(radio_ctrl_pkg::LEGACY_TIMING_LEN);
   // width bit ignored in extended mode
   assign discriminator_range_o = ext_mode ? discriminator_range_i
                                           : {1'b0, main_control_r[radio_ctrl_pkg::BIT_DISC_WIDTH]};

   // ==========================================
   // Data pin synchroniser and polarity
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_s3_r;
   logic pin_r;
   logic tx_symbol;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
         pin_r <= 1'b0;
      end else if (ce_i) begin
         pin_s1_r <= rx_tx_data_pin_i;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         if (pin_s2_r == pin_s3_r) begin
            pin_r <= pin_s3_r;
         end
      end
   end

   // polarity applied to the transmit symbol
   assign tx_symbol = polarity ? pin_r : ~pin_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_reg_index_o <= radio_ctrl_pkg::MAIN_RESET[radio_ctrl_pkg::RX_FREQ_SELECT_HI:radio_ctrl_pkg::RX_FREQ_SELECT_LO];
      end else if (ce_i) begin
         if (tx_mode) begin
            freq_reg_index_o <= {main_control_r[radio_ctrl_pkg::BIT_TX_PAIR], tx_symbol};
         end else begin
            freq_reg_index_o <= main_control_r[radio_ctrl_pkg::RX_FREQ_SELECT_HI:radio_ctrl_pkg::RX_FREQ_SELECT_LO];
         end
      end
   end

   // received data polarity and validation gate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_tx_data_pin_o <= 1'b0;
      end else if (ce_i) begin
         rx_tx_data_pin_o <= (val_state_r == radio_ctrl_pkg::VAL_VALID) & (polarity ? demod_bit_i : ~demod_bit_i);
      end
   end

   assign rx_tx_data_pin_oe_o = power_on & ~tx_mode;
   assign data_valid_o = val_state_r;

   // ==========================================
   // Shared ADC capture
   logic strength_upd;
   assign strength_upd = adc_valid_i & ~supply_active;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         measured_strength_r <= 6'h00;
      end else if (ce_i && strength_upd) begin
         measured_strength_r <= adc_value_i;
      end
   end

   // supply result into its own field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_value_r <= 6'h00;
      end else if (ce_i && adc_valid_i && supply_active) begin
         supply_value_r <= adc_value_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         offset_value_r <= 6'h00;
      end else if (ce_i && offset_valid_i && main_control_r[radio_ctrl_pkg::BIT_OFFSET_MEAS]) begin
         offset_value_r <= offset_value_i;
      end
   end

   // ==========================================
   // Hysteresis decision, taken on each new strength sample
   logic signed [7:0] high_lvl;
   logic signed [7:0] low_lvl;
   logic signed [7:0] sample_s;

   always_comb begin
      high_lvl = signed'({2'b00, threshold}) + signed'({5'b0_0000, hysteresis});
      low_lvl = signed'({2'b00, threshold}) - signed'({5'b0_0000, hysteresis});
      sample_s = signed'({2'b00, adc_value_i});
      val_state_nxt = val_state_r;
      if (strength_upd) begin
         if (sample_s >= high_lvl) begin
            val_state_nxt = radio_ctrl_pkg::VAL_VALID;
         end else if (sample_s < low_lvl) begin
            val_state_nxt = radio_ctrl_pkg::VAL_INHIBITED;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         val_state_r <= radio_ctrl_pkg::VAL_INHIBITED;
      end else if (ce_i) begin
         val_state_r <= val_state_nxt;
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held more than one cycle");
   a_ack_follows_req: assert property (req && !ack_o |=> ack_o) else $error("request not acked");
   // Reset checks look across the reset edge, so the default disable is switched off for them
   a_reset_loads: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
      main_control_r == radio_ctrl_pkg::MAIN_RESET && rate_and_lock_control_r == radio_ctrl_pkg::RATE_RESET)
      else $error("reset value wrong");
   a_thr_reset: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
      threshold == 6'h00 && hysteresis == 3'h0) else $error("threshold or hysteresis not reset");
   a_resv_zero: assert property ((main_control_r & radio_ctrl_pkg::MAIN_RESV_MASK) == 32'h0000_0000)
      else $error("reserved bits set");
   a_power_field: assert property (tx_power_level_o ==
      main_control_r[radio_ctrl_pkg::TX_POWER_LEVEL_HI:radio_ctrl_pkg::TX_POWER_LEVEL_LO]) else $error("power level");
   a_tx_pair_sel: assert property (tx_mode && $stable(main_control_r) |=>
      freq_reg_index_o == {$past(main_control_r[radio_ctrl_pkg::BIT_TX_PAIR]), $past(tx_symbol)})
      else $error("tx pair index");
   a_rx_reg_sel: assert property (!tx_mode |=>
      freq_reg_index_o == $past(main_control_r[radio_ctrl_pkg::RX_FREQ_SELECT_HI:radio_ctrl_pkg::RX_FREQ_SELECT_LO]))
      else $error("rx register index");
   a_crystal_field: assert property (crystal_select_o == main_control_r[radio_ctrl_pkg::BIT_CRYSTAL])
      else $error("crystal select");
   a_legacy_width: assert property (!ext_mode |->
      discriminator_range_o == {1'b0, main_control_r[radio_ctrl_pkg::BIT_DISC_WIDTH]})
      else $error("width used in wrong mode");
   a_ext_range: assert property (ext_mode |-> discriminator_range_o == discriminator_range_i)
      else $error("extended range not used");
   a_rx_polarity: assert property (val_state_r == radio_ctrl_pkg::VAL_VALID |=>
      rx_tx_data_pin_o == ($past(polarity) ? $past(demod_bit_i) : !$past(demod_bit_i))) else $error("polarity");
   a_slicer_field: assert property (slicer_reference_select_o ==
      main_control_r[radio_ctrl_pkg::BIT_SLICER_REF]) else $error("slicer reference");
   a_adc_route: assert property (adc_offset_measure_o ==
      main_control_r[radio_ctrl_pkg::BIT_OFFSET_MEAS]) else $error("adc routing");
   a_timing_len: assert property (extended_mode_enable_o |->
      timing_length_o == 6'(radio_ctrl_pkg::EXT_TIMING_LEN)) else $error("extended timing length");
   a_strength_frozen: assert property (supply_active |=> $stable(measured_strength_r))
      else $error("strength moved during supply");
   a_no_supply_off: assert property (!power_on |=> $stable(supply_value_r)) else $error("supply in power down");
   a_supply_gate: assert property (supply_measure_active_o |-> power_on) else $error("supply while down");
   a_offset_concurrent: assert property (offset_valid_i && main_control_r[radio_ctrl_pkg::BIT_OFFSET_MEAS] |=>
      offset_value_r == $past(offset_value_i)) else $error("offset not captured");
   // Levels are worked out here in unsigned form, apart from the signed datapath above
   a_validate_high: assert property (adc_valid_i && !supply_active
      && 7'(adc_value_i) >= 7'(threshold) + 7'(hysteresis) |=> data_valid_o) else $error("not validated");
   a_inhibit_low: assert property (adc_valid_i && !supply_active
      && 7'(adc_value_i) + 7'(hysteresis) < 7'(threshold) |=> !data_valid_o) else $error("not inhibited");
   a_rx_gated: assert property (!data_valid_o |=> !rx_tx_data_pin_o) else $error("data not inhibited");
   a_hold_between: assert property ((!adc_valid_i || supply_active
      || (7'(adc_value_i) < 7'(threshold) + 7'(hysteresis) && 7'(adc_value_i) + 7'(hysteresis) >= 7'(threshold)))
      |=> $stable(data_valid_o)) else $error("decision changed between levels");
   a_supply_store: assert property (adc_valid_i && supply_active |=> supply_value_r == $past(adc_value_i))
      else $error("supply not stored");

   c_full_write: cover property (wr_take && adr_i == radio_ctrl_pkg::OFS_MAIN && sel_i == radio_ctrl_pkg::SEL_ALL);
   c_validate: cover property (val_state_r == radio_ctrl_pkg::VAL_INHIBITED ##1 val_state_r == radio_ctrl_pkg::VAL_VALID);
   c_inhibit: cover property (val_state_r == radio_ctrl_pkg::VAL_VALID ##1 val_state_r == radio_ctrl_pkg::VAL_INHIBITED);
   c_supply_sample: cover property (adc_valid_i && supply_active);
   c_tx_pair: cover property (tx_mode && main_control_r[radio_ctrl_pkg::BIT_TX_PAIR] && tx_symbol);

endmodule

/* File: rtl/radio_ctrl_pkg.sv */
// Package: register map, field layout, reset values and states of the radio control bank
package radio_ctrl_pkg;

   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_MAIN = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // ==========================================
   // Reset values
   localparam logic [31:0] MAIN_RESET = 32'h1000_0270;
   localparam logic [31:0] RATE_RESET = 32'h0000_0057;
   // Reserved bits 10, 3 and 2 of main_control
   localparam logic [31:0] MAIN_RESV_MASK = 32'h0000_040C;
   localparam logic [3:0] SEL_ALL = 4'hF;

   // ==========================================
   // main_control field positions
   localparam int BIT_POWER_ON = 31;
   localparam int BIT_TX_MODE = 30;
   localparam int BIT_SUPPLY_SEL = 24;
   localparam int THR_HI = 23;
   localparam int THR_LO = 18;
   localparam int HYS_HI = 17;
   localparam int HYS_LO = 15;
   localparam int TX_POWER_LEVEL_HI = 14;
   localparam int TX_POWER_LEVEL_LO = 12;
   localparam int BIT_TX_PAIR = 11;
   localparam int RX_FREQ_SELECT_HI = 9;
   localparam int RX_FREQ_SELECT_LO = 8;
   localparam int BIT_CRYSTAL = 7;
   localparam int BIT_DISC_WIDTH = 6;
   localparam int BIT_POLARITY = 5;
   localparam int BIT_SLICER_REF = 4;
   localparam int BIT_OFFSET_MEAS = 1;
   localparam int BIT_EXT_MODE = 0;

   // ==========================================
   // status field positions
   localparam int ST_VALID = 31;
   localparam int ST_STR_HI = 29;
   localparam int ST_STR_LO = 24;
   localparam int ST_SUP_HI = 23;
   localparam int ST_SUP_LO = 18;
   localparam int ST_OFS_HI = 5;
   localparam int ST_OFS_LO = 0;

   // ==========================================
   // Widths and timing
   localparam int ADC_W = 6;
   localparam int EXT_TIMING_LEN = 32;
   localparam int LEGACY_TIMING_LEN = 24;

   typedef enum logic {
      VAL_INHIBITED = 1'b0,
      VAL_VALID = 1'b1
   } valid_state_e;

endpackage

/* File: sim/adc_source.sv */
// Behavioural model of the converter feeding strength, supply and offset samples
`timescale 1ns/1ps
module adc_source (
   // Clock
   input wire logic clk_i,
   // Samples
   output logic adc_valid_o,
   output logic [5:0] adc_value_o,
   output logic offset_valid_o,
   output logic [5:0] offset_value_o
);
   initial begin
      adc_valid_o = 1'b0;
      adc_value_o = 6'h00;
      offset_valid_o = 1'b0;
      offset_value_o = 6'h00;
   end

   // ==========================================
   // One-cycle sample; the value is scrambled afterwards so stale data cannot look valid
   task automatic send(input logic offs, input logic [5:0] v);
      @(posedge clk_i);
      if (offs) begin
         offset_valid_o <= 1'b1;
         offset_value_o <= v;
      end else begin
         adc_valid_o <= 1'b1;
         adc_value_o <= v;
      end
      @(posedge clk_i);
      adc_valid_o <= 1'b0;
      offset_valid_o <= 1'b0;
      adc_value_o <= ~v;
      offset_value_o <= ~v;
   endtask
endmodule

/* File: sim/radio_ctrl_tb_top.sv */
// Self-checking bench for the radio control register bank
`timescale 1ns/1ps
module radio_ctrl_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, demod_bit_i = 1'b0;
   logic rx_tx_data_pin_i = 1'b0, adc_valid_i, offset_valid_i, rx_tx_data_pin_o, rx_tx_data_pin_oe_o;
   logic crystal_select_o, slicer_reference_select_o, adc_offset_measure_o, supply_measure_active_o;
   logic extended_mode_enable_o, data_valid_o, ack_o, ce_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, rate_and_lock_control_o, w;
   logic [5:0] adc_value_i, offset_value_i, timing_length_o;
   logic [1:0] discriminator_range_i = 2'h0, freq_reg_index_o, discriminator_range_o;
   logic [2:0] tx_power_level_o;
   logic [31:0] rd_q[$];
   int mismatches = 0, comparisons = 0, cycles = 0, seed = 5088;
   logic [5:0] seq[10] = '{27, 32, 35, 36, 35, 32, 29, 28, 27, 25};
   logic seq_ok[10] = '{0, 0, 0, 1, 1, 1, 1, 1, 0, 0};

   always #2.5 clk_i = ~clk_i;

   radio_ctrl radio_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .adc_valid_i(adc_valid_i), .adc_value_i(adc_value_i), .offset_valid_i(offset_valid_i),
      .offset_value_i(offset_value_i), .demod_bit_i(demod_bit_i), .discriminator_range_i(discriminator_range_i),
      .rx_tx_data_pin_i(rx_tx_data_pin_i), .rx_tx_data_pin_o(rx_tx_data_pin_o),
      .rx_tx_data_pin_oe_o(rx_tx_data_pin_oe_o), .tx_power_level_o(tx_power_level_o),
      .freq_reg_index_o(freq_reg_index_o), .crystal_select_o(crystal_select_o),
      .discriminator_range_o(discriminator_range_o), .slicer_reference_select_o(slicer_reference_select_o),
      .adc_offset_measure_o(adc_offset_measure_o), .supply_measure_active_o(supply_measure_active_o),
      .extended_mode_enable_o(extended_mode_enable_o), .timing_length_o(timing_length_o),
      .data_valid_o(data_valid_o), .rate_and_lock_control_o(rate_and_lock_control_o));

   adc_source adc_source_inst (.clk_i(clk_i), .adc_valid_o(adc_valid_i), .adc_value_o(adc_value_i),
      .offset_valid_o(offset_valid_i), .offset_value_o(offset_value_i));

   // ==========================================
   // Checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Read data is taken only at the edge where ack is seen
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) chk(dat_o, rd_q.pop_front());
   end

   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 20000) begin
         mismatches++;
         close_out();
      end
   end

   // ==========================================
   // Wishbone classic master
   task automatic wb(input logic wr, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      // Only the bench timeout ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      wb(1'b0, a, radio_ctrl_pkg::SEL_ALL, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, radio_ctrl_pkg::SEL_ALL, d);
      @(posedge clk_i);
   endtask

   task automatic field_chk(input logic [31:0] v);
      chk(32'(tx_power_level_o), 32'(v[14:12]));
      chk(32'(freq_reg_index_o), 32'(v[9:8]));
      chk(32'(crystal_select_o), 32'(v[7]));
      chk(32'(discriminator_range_o), v[0] ? 32'(discriminator_range_i) : 32'({1'b0, v[6]}));
      chk(32'(slicer_reference_select_o), 32'(v[4]));
      chk(32'(adc_offset_measure_o), 32'(v[1]));
      chk(32'(extended_mode_enable_o), 32'(v[0]));
      chk(32'(timing_length_o), v[0] ? 32'd32 : 32'd24);
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(radio_ctrl_pkg::OFS_MAIN, 32'h1000_0270);
      rd(radio_ctrl_pkg::OFS_RATE, 32'h0000_0057);
      rd(radio_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
      field_chk(32'h1000_0270);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         w = $random(seed) & ~radio_ctrl_pkg::MAIN_RESV_MASK & 32'h3FFF_FFFF;
         discriminator_range_i <= 2'($random(seed));
         wr(radio_ctrl_pkg::OFS_MAIN, w);
         rd(radio_ctrl_pkg::OFS_MAIN, w);
         field_chk(w);
      end
      w = $random(seed);
      wr(radio_ctrl_pkg::OFS_RATE, w);
      wb(1'b1, radio_ctrl_pkg::OFS_RATE, 4'h3, ~w);
      wb(1'b1, radio_ctrl_pkg::OFS_STATUS, radio_ctrl_pkg::SEL_ALL, 32'hFFFF_FFFF);
      rd(radio_ctrl_pkg::OFS_RATE, w);
      chk(rate_and_lock_control_o, w);
      rd(8'h3C, 32'h0000_0000);
      $display("test field decode done");
      // Threshold 32, hysteresis 4, powered, receive, direct polarity
      wr(radio_ctrl_pkg::OFS_MAIN, 32'h8082_0220);
      for (int i = 0; i < 10; i++) begin
         adc_source_inst.send(1'b0, seq[i]);
         @(posedge clk_i);
         chk(32'(data_valid_o), 32'(seq_ok[i]));
      end
      rd(radio_ctrl_pkg::OFS_STATUS, 32'h1900_0000);
      adc_source_inst.send(1'b0, 6'd40);
      @(posedge clk_i);
      chk(32'(data_valid_o), 32'h1);
      // Enable low: a sample that would inhibit must leave all state alone
      ce_i <= 1'b0;
      adc_source_inst.send(1'b0, 6'd5);
      @(posedge clk_i);
      chk(32'(data_valid_o), 32'h1);
      ce_i <= 1'b1;
      rd(radio_ctrl_pkg::OFS_STATUS, 32'hA800_0000);
      $display("test hysteresis done");
      for (int p = 0; p < 2; p++) begin
         wr(radio_ctrl_pkg::OFS_MAIN, p ? 32'h8082_0200 : 32'h8082_0220);
         for (int b = 0; b < 2; b++) begin
            demod_bit_i <= b[0];
            repeat (3) @(posedge clk_i);
            chk(32'(rx_tx_data_pin_o), 32'(b[0] ^ p[0]));
         end
      end
      $display("test polarity done");
      // Supply select on: a low sample goes to the supply field and must leave strength and the decision alone
      wr(radio_ctrl_pkg::OFS_MAIN, 32'h8182_0222);
      chk(32'(supply_measure_active_o), 32'h1);
      adc_source_inst.send(1'b0, 6'd5);
      adc_source_inst.send(1'b1, 6'h15);
      @(posedge clk_i);
      chk(32'(data_valid_o), 32'h1);
      rd(radio_ctrl_pkg::OFS_STATUS, 32'hA814_0015);
      wr(radio_ctrl_pkg::OFS_MAIN, 32'h0182_0222);
      chk(32'(supply_measure_active_o), 32'h0);
      $display("test supply measure done");
      for (int f = 0; f < 4; f++) begin
         wr(radio_ctrl_pkg::OFS_MAIN, f[1] ? 32'hC082_0A20 : 32'hC082_0220);
         rx_tx_data_pin_i <= f[0];
         repeat (8) @(posedge clk_i);
         chk(32'(freq_reg_index_o), 32'(f[1:0]));
         chk(32'(rx_tx_data_pin_oe_o), 32'h0);
      end
      $display("test transmit pair done");
      close_out();
   end
endmodule
